/* File: ntw_field.sv */
// One 32-bit register with per-port write masks
module ntw_field #(
  parameter logic [31:0] RST   = 32'h0000_0000,
  parameter logic [31:0] PMASK = 32'h0000_0000,
  parameter logic [31:0] SMASK = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic sys_rst,
  ntw_fld_if.fld   fi
);

  ntw_pkg::ntw_fld_st_t st_r;
  ntw_pkg::ntw_fld_st_t st_nxt;

  // Primary write first, then secondary, so secondary wins a collision
  always_comb begin
    logic [31:0] pm;
    logic [31:0] sm;
    pm = fi.pwe & PMASK;
    sm = fi.swe & SMASK;
    st_nxt = st_r;
    st_nxt.q = (st_r.q & ~pm) | (fi.pwd & pm);
    st_nxt.q = (st_nxt.q & ~sm) | (fi.swd & sm);
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{q: RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fi.q = st_r.q;

endmodule

/* File: ntw_fld_if.sv */
// Write strobes and stored value between the bank and one register
interface ntw_fld_if;
  logic [31:0] pwe;
  logic [31:0] pwd;
  logic [31:0] swe;
  logic [31:0] swd;
  logic [31:0] q;
  modport ctrl (output pwe, output pwd, output swe, output swd, input q);
  modport fld  (input pwe, input pwd, input swe, input swd, output q);
endinterface

/* File: ntw_host.sv */
// Host model that issues single-word accesses on one bridge port
module ntw_host (
  input  wire logic        clk,
  output logic             req,
  output logic             we,
  output logic [11:2]      addr,
  output logic [31:0]      wdata,
  output logic [3:0]       be,
  input  wire logic        ack,
  input  wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle port at time zero
  initial begin
    req = 1'b0;
    we = 1'b0;
    addr = '0;
    wdata = '0;
    be = '0;
  end

  // One access: pulse the request, hold the qualifiers through the answer,
  // then invert address and write data so that the bank must ignore idle address lines
  task automatic acc(input logic w, input logic [11:0] ofs,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    req = 1'b1;
    we = w;
    addr = ofs[11:2];
    wdata = d;
    be = b;
    @(posedge clk);
    #1;
    req = 1'b0;
    while (ack !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    q = (ack === 1'b1) ? rdata : 'x;
    @(posedge clk);
    #1;
    addr = ~addr;
    wdata = ~wdata;
  endtask
endmodule

/* File: ntw_pkg.sv */
// Constants and types for the bridge memory-window setup registers
package ntw_pkg;

  localparam int NREG = 7;

  // Byte offsets of the implemented registers
  localparam logic [11:0] OFS_DN2_BASE  = 12'h008;
  localparam logic [11:0] OFS_DN2_SETUP = 12'h00c;
  localparam logic [11:0] OFS_DN3_BASE  = 12'h010;
  localparam logic [11:0] OFS_DN3_SETUP = 12'h014;
  localparam logic [11:0] OFS_DN3_UPPER = 12'h018;
  localparam logic [11:0] OFS_UP3_SETUP = 12'h034;
  localparam logic [11:0] OFS_UP3_UPPER = 12'h038;

  // Register indices inside the bank
  localparam int IDX_DN2_BASE  = 0;
  localparam int IDX_DN2_SETUP = 1;
  localparam int IDX_DN3_BASE  = 2;
  localparam int IDX_DN3_SETUP = 3;
  localparam int IDX_DN3_UPPER = 4;
  localparam int IDX_UP3_SETUP = 5;
  localparam int IDX_UP3_UPPER = 6;

  // Field positions
  localparam int BASE_LSB   = 12;
  localparam int SIZE_MSB   = 30;
  localparam int EN_BIT     = 31;
  localparam int PREF_BIT   = 3;
  localparam int ATYPE_LSB  = 1;
  localparam int MEMSEL_BIT = 0;
  localparam logic [1:0] ATYPE_32 = 2'h0;
  localparam logic [1:0] ATYPE_64 = 2'h1;

  // Reset values
  localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
  localparam logic [31:0] RST_UP3_S = 32'h0000_0002;

  // Bits writable from the primary and from the secondary port
  localparam logic [31:0] WM_BASE   = 32'hffff_f000;
  localparam logic [31:0] WM_DSETUP = 32'hffff_f00e;
  localparam logic [31:0] WM_ALL    = 32'hffff_ffff;
  localparam logic [31:0] WM_USETUP = 32'hffff_f008;
  localparam logic [31:0] WM_UUPPER = 32'h7fff_ffff;
  localparam logic [31:0] WM_NONE   = 32'h0000_0000;

  localparam logic [11:0] REG_OFS [NREG] = '{OFS_DN2_BASE, OFS_DN2_SETUP,
    OFS_DN3_BASE, OFS_DN3_SETUP, OFS_DN3_UPPER, OFS_UP3_SETUP, OFS_UP3_UPPER};
  localparam logic [31:0] REG_RST [NREG] = '{RST_ZERO, RST_ZERO, RST_ZERO,
    RST_ZERO, RST_ZERO, RST_UP3_S, RST_ZERO};
  localparam logic [31:0] PRI_WM [NREG] = '{WM_BASE, WM_NONE, WM_BASE,
    WM_NONE, WM_ALL, WM_USETUP, WM_UUPPER};
  localparam logic [31:0] SEC_WM [NREG] = '{WM_BASE, WM_DSETUP, WM_BASE,
    WM_DSETUP, WM_ALL, WM_USETUP, WM_UUPPER};

  typedef struct packed {
    logic [31:0] q;
  } ntw_fld_st_t;

  typedef struct packed {
    logic        p_ack;
    logic [31:0] p_rd;
    logic        s_ack;
    logic [31:0] s_rd;
    logic        x_vld;
    logic        x_hit;
    logic [31:0] x_addr;
  } ntw_top_st_t;

endpackage

/* File: ntw_window_setup_regs.sv */
// Memory-window translation and setup registers of a bridge
// Notes on behaviour
// - Register reads and writes from primary and secondary ports are served.
// - Secondary-only fields ignore primary writes; both ports read them.
// - Window 2 translated base is bits 31:12, low bits read zero.
// - Window 3 translated base is bits 31:12, low bits read zero.
// - Only size-marked upper address bits are replaced by the base.
// - Setup bit 0 reads zero: memory space requested.
// - Address type 00 is 32-bit, 01 64-bit; upstream window 3 fixed 01.
// - Downstream size bits 30:12 mark the base bits substituted in translation, reset zero.
// - Upstream window 3 size spans bits 31:12, read/write.
// - Downstream setup bit 31 enables the window, secondary-only.
// - Upper setup bits 30:0 are read/write size bits, reset zero.
// - Downstream window 3 upper bit 31 enables 64-bit base, read/write.
module ntw_window_setup_regs (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        pri_req,
  input  wire logic        pri_we,
  input  wire logic [11:2] pri_addr,
  input  wire logic [31:0] pri_wdata,
  input  wire logic [3:0]  pri_be,
  output logic             pri_ack,
  output logic [31:0]      pri_rdata,
  input  wire logic        sec_req,
  input  wire logic        sec_we,
  input  wire logic [11:2] sec_addr,
  input  wire logic [31:0] sec_wdata,
  input  wire logic [3:0]  sec_be,
  output logic             sec_ack,
  output logic [31:0]      sec_rdata,
  input  wire logic        xl_req,
  input  wire logic        xl_win3,
  input  wire logic [31:0] xl_addr_in,
  output logic             xl_valid,
  output logic             xl_hit,
  output logic [31:0]      xl_addr_out
);

  localparam int N = ntw_pkg::NREG;

  ntw_pkg::ntw_top_st_t st_r;
  ntw_pkg::ntw_top_st_t st_nxt;
  logic [31:0]          q_w [N];
  ntw_fld_if            fif [N] ();

  // Byte enables widened to bit enables
  function automatic logic [31:0] be_bits(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  // Read mux; unmapped offsets return zero
  function automatic logic [31:0] rd_mux(input logic [11:2] a,
                                         input logic [31:0] qv [N]);
    logic [31:0] d;
    d = '0;
    for (int k = 0; k < N; k++) begin
      if (a == ntw_pkg::REG_OFS[k][11:2]) begin
        d = qv[k];
      end
    end
    return d;
  endfunction

  // Register instances; write masks enforce port rights and reserved bits
  for (genvar i = 0; i < N; i++) begin : g_reg
    logic p_hit;
    logic s_hit;
    assign p_hit = pri_req && pri_we &&
                   (pri_addr == ntw_pkg::REG_OFS[i][11:2]);
    assign s_hit = sec_req && sec_we &&
                   (sec_addr == ntw_pkg::REG_OFS[i][11:2]);
    assign fif[i].pwe = p_hit ? be_bits(pri_be) : 32'h0000_0000;
    assign fif[i].pwd = pri_wdata;
    assign fif[i].swe = s_hit ? be_bits(sec_be) : 32'h0000_0000;
    assign fif[i].swd = sec_wdata;
    assign q_w[i] = fif[i].q;
    ntw_field #(
      .RST   (ntw_pkg::REG_RST[i]),
      .PMASK (ntw_pkg::PRI_WM[i]),
      .SMASK (ntw_pkg::SEC_WM[i])
    ) u_fld (
      .clk     (clk),
      .sys_rst (sys_rst),
      .fi      (fif[i].fld)
    );
  end

  // Bus answers and address translation for the next cycle
  always_comb begin
    logic [31:0] setup;
    logic [31:0] base;
    logic [19:0] mask;
    setup = xl_win3 ? q_w[ntw_pkg::IDX_DN3_SETUP]
                    : q_w[ntw_pkg::IDX_DN2_SETUP];
    base  = xl_win3 ? q_w[ntw_pkg::IDX_DN3_BASE]
                    : q_w[ntw_pkg::IDX_DN2_BASE];
    mask  = {setup[ntw_pkg::SIZE_MSB],
             setup[ntw_pkg::SIZE_MSB:ntw_pkg::BASE_LSB]};
    st_nxt = st_r;
    st_nxt.p_ack = pri_req;
    st_nxt.p_rd  = (pri_req && !pri_we) ? rd_mux(pri_addr, q_w)
                                         : 32'h0000_0000;
    st_nxt.s_ack = sec_req;
    st_nxt.s_rd  = (sec_req && !sec_we) ? rd_mux(sec_addr, q_w)
                                         : 32'h0000_0000;
    st_nxt.x_vld = xl_req;
    st_nxt.x_hit = xl_req && setup[ntw_pkg::EN_BIT];
    st_nxt.x_addr = {(base[31:12] & mask) |
                     (xl_addr_in[31:12] & ~mask),
                     xl_addr_in[11:0]};
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pri_ack     = st_r.p_ack;
  assign pri_rdata   = st_r.p_rd;
  assign sec_ack     = st_r.s_ack;
  assign sec_rdata   = st_r.s_rd;
  assign xl_valid    = st_r.x_vld;
  assign xl_hit      = st_r.x_hit;
  assign xl_addr_out = st_r.x_addr;

  // Checks on answers, port rights and translation
  logic [31:0] q_d2s;
  logic [31:0] q_d3s;
  logic [31:0] q_u3s;
  logic [31:0] q_d2b;
  assign q_d2s = q_w[ntw_pkg::IDX_DN2_SETUP];
  assign q_d3s = q_w[ntw_pkg::IDX_DN3_SETUP];
  assign q_u3s = q_w[ntw_pkg::IDX_UP3_SETUP];
  assign q_d2b = q_w[ntw_pkg::IDX_DN2_BASE];

  property p_pri_ack;
    @(posedge clk) disable iff (sys_rst)
    pri_req |=> pri_ack;
  endproperty
  a_pri_ack: assert property (p_pri_ack)
    else $error("primary access not answered");

  property p_sec_ack;
    @(posedge clk) disable iff (sys_rst)
    !sec_req |=> !sec_ack;
  endproperty
  a_sec_ack: assert property (p_sec_ack)
    else $error("secondary answer without request");

  property p_pri_no_write;
    @(posedge clk) disable iff (sys_rst)
    (pri_req && pri_we && pri_addr == ntw_pkg::OFS_DN2_SETUP[11:2] &&
     !sec_req) |=> $stable(q_d2s);
  endproperty
  a_pri_no_write: assert property (p_pri_no_write)
    else $error("primary write changed secondary-only setup");

  property p_base_low;
    @(posedge clk) disable iff (sys_rst)
    (sec_req && !sec_we && (sec_addr == ntw_pkg::OFS_DN2_BASE[11:2] ||
     sec_addr == ntw_pkg::OFS_DN3_BASE[11:2])) |=> sec_rdata[11:0] == '0;
  endproperty
  a_base_low: assert property (p_base_low)
    else $error("translated base low bits not zero");

  property p_base_store;
    @(posedge clk) disable iff (sys_rst)
    (pri_req && pri_we && pri_be == 4'hf && !sec_req &&
     pri_addr == ntw_pkg::OFS_DN2_BASE[11:2])
    |=> q_d2b == {$past(pri_wdata[31:12]), 12'h000};
  endproperty
  a_base_store: assert property (p_base_store)
    else $error("translated base write not stored");

  property p_xlat;
    @(posedge clk) disable iff (sys_rst)
    (xl_req && !xl_win3 && q_d2s[30:12] == '0)
    |=> xl_addr_out == $past(xl_addr_in);
  endproperty
  a_xlat: assert property (p_xlat)
    else $error("address changed with empty size mask");

  property p_fixed_bits;
    @(posedge clk) disable iff (sys_rst)
    !q_d2s[0] && !q_d3s[0] && !q_u3s[0] && q_u3s[2:1] == ntw_pkg::ATYPE_64;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("fixed setup bits changed");

  property p_hit_en;
    @(posedge clk) disable iff (sys_rst)
    xl_req ##1 xl_hit |-> $past(xl_win3 ? q_d3s[31] : q_d2s[31]);
  endproperty
  a_hit_en: assert property (p_hit_en)
    else $error("hit reported for a disabled window");

  property p_unmapped;
    @(posedge clk) disable iff (sys_rst)
    (pri_req && !pri_we && pri_addr == 10'h000) |=> pri_rdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("reserved offset read not zero");

  c_sec_setup_wr: cover property (@(posedge clk) disable iff (sys_rst)
    sec_req && sec_we && sec_addr == ntw_pkg::OFS_DN3_SETUP[11:2]);
  c_xlat_hit: cover property (@(posedge clk) disable iff (sys_rst)
    xl_hit && xl_addr_out != $past(xl_addr_in, 1));
  c_both_ports: cover property (@(posedge clk) disable iff (sys_rst)
    pri_req && sec_req);

endmodule

/* File: ntw_window_setup_regs_bench.sv */
// Self-checking bench for the window setup registers
module ntw_window_setup_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        s;
    logic [11:0] o;
    logic [31:0] d;
    logic [31:0] e;
  } ntw_row_t;

  logic        clk, sys_rst, pri_req, pri_we, pri_ack, sec_req, sec_we;
  logic        sec_ack, xl_req, xl_win3, xl_valid, xl_hit;
  logic [11:2] pri_addr, sec_addr;
  logic [31:0] pri_wdata, pri_rdata, sec_wdata, sec_rdata;
  logic [31:0] xl_addr_in, xl_addr_out, q, q2;
  logic [3:0]  pri_be, sec_be;
  int          fail_count = 0;
  int          compares = 0;

  // Port, offset, write data, value read back through the other port
  ntw_row_t rows [11] = '{
    '{1'b0, 12'h008, 32'hffff_ffff, 32'hffff_f000},
    '{1'b0, 12'h00c, 32'hffff_ffff, 32'h0000_0000},
    '{1'b1, 12'h00c, 32'hffff_ffff, 32'hffff_f00e},
    '{1'b1, 12'h014, 32'hffff_ffff, 32'hffff_f00e},
    '{1'b0, 12'h010, 32'hffff_ffff, 32'hffff_f000},
    '{1'b0, 12'h018, 32'hffff_ffff, 32'hffff_ffff},
    '{1'b0, 12'h034, 32'hffff_ffff, 32'hffff_f00a},
    '{1'b1, 12'h038, 32'hffff_ffff, 32'h7fff_ffff},
    '{1'b0, 12'h03c, 32'hffff_ffff, 32'h0000_0000},
    '{1'b1, 12'h000, 32'hffff_ffff, 32'h0000_0000},
    '{1'b1, 12'h034, 32'h0000_0000, 32'h0000_0002}};

  ntw_window_setup_regs uut (.clk, .sys_rst, .pri_req, .pri_we,
    .pri_addr, .pri_wdata, .pri_be, .pri_ack, .pri_rdata, .sec_req,
    .sec_we, .sec_addr, .sec_wdata, .sec_be, .sec_ack, .sec_rdata,
    .xl_req, .xl_win3, .xl_addr_in, .xl_valid, .xl_hit, .xl_addr_out);
  ntw_host ph (.clk, .req(pri_req), .we(pri_we), .addr(pri_addr),
    .wdata(pri_wdata), .be(pri_be), .ack(pri_ack), .rdata(pri_rdata));
  ntw_host sh (.clk, .req(sec_req), .we(sec_we), .addr(sec_addr),
    .wdata(sec_wdata), .be(sec_be), .ack(sec_ack), .rdata(sec_rdata));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Every register reads its reset value
  task automatic rst_chk();
    for (int i = 0; i < ntw_pkg::NREG; i++) begin
      sh.acc(1'b0, ntw_pkg::REG_OFS[i], '0, 4'hf, q);
      chk(q, ntw_pkg::REG_RST[i]);
    end
  endtask

  // One translation request and its answer a cycle later
  task automatic xl(input logic w3, input logic [31:0] a,
                    input logic h, input logic [31:0] e);
    @(posedge clk);
    #1;
    xl_req = 1'b1;
    xl_win3 = w3;
    xl_addr_in = a;
    @(posedge clk);
    #1;
    xl_req = 1'b0;
    xl_addr_in = ~a;
    chk({31'h0, xl_valid}, 32'h1);
    chk({31'h0, xl_hit}, {31'h0, h});
    chk(xl_addr_out, e);
  endtask

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Watchdog
  initial begin
    #50000;
    fail_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    xl_req = 1'b0;
    xl_win3 = 1'b0;
    xl_addr_in = '0;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    rst_chk();
    foreach (rows[i]) begin
      if (rows[i].s) begin
        sh.acc(1'b1, rows[i].o, rows[i].d, 4'hf, q);
        chk(q, 32'h0000_0000);
        ph.acc(1'b0, rows[i].o, '0, 4'hf, q);
      end else begin
        ph.acc(1'b1, rows[i].o, rows[i].d, 4'hf, q);
        chk(q, 32'h0000_0000);
        sh.acc(1'b0, rows[i].o, '0, 4'hf, q);
      end
      chk(q, rows[i].e);
    end
    // Masked substitution, enabled and disabled windows
    sh.acc(1'b1, 12'h00c, 32'h8000_f000, 4'hf, q);
    ph.acc(1'b1, 12'h008, 32'h1234_5000, 4'hf, q);
    xl(1'b0, 32'hffff_fabc, 1'b1, 32'hffff_5abc);
    sh.acc(1'b1, 12'h014, 32'h0000_f000, 4'hf, q);
    xl(1'b1, 32'h0123_4567, 1'b0, 32'h0123_f567);
    // Same-cycle writes from both ports, then a single-lane write
    fork
      ph.acc(1'b1, 12'h008, 32'h1111_1000, 4'hf, q);
      sh.acc(1'b1, 12'h008, 32'h2222_2000, 4'hf, q2);
    join
    chk(q, 32'h0000_0000);
    chk(q2, 32'h0000_0000);
    ph.acc(1'b1, 12'h008, 32'haa55_5555, 4'h8, q);
    ph.acc(1'b0, 12'h008, '0, 4'hf, q);
    chk(q, 32'haa22_2000);
    // Second reset in mid-run, then an empty size mask passes addresses
    sys_rst = 1'b1;
    @(posedge clk);
    #1;
    sys_rst = 1'b0;
    rst_chk();
    xl(1'b0, 32'h89ab_cdef, 1'b0, 32'h89ab_cdef);
    end_sim();
  end
endmodule
